// ### rtl/can_bit_timing_pkg.sv
// Package for the CAN bit timing block: register map, fields, timing constants
package can_bit_timing_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_PRESCALE = 8'h00;
  localparam logic [7:0] OFS_SEGMENT  = 8'h04;
  localparam logic [7:0] OFS_CONTROL  = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;

  // Field positions in the segment register
  localparam int SEG1_LSB = 0;
  localparam int SEG2_LSB = 8;
  localparam int SJW_LSB  = 16;
  localparam int FIELD_W  = 5;

  // Reset values: 40 MHz clock, quantum of 40 clocks -> 8 quanta of 1000 ns (8 x 40 = 320 clk)
  localparam logic [7:0] PRESCALE_RST = 8'h27;
  localparam logic [4:0] SEG1_RST     = 5'h04;
  localparam logic [4:0] SEG2_RST     = 5'h03;
  localparam logic [4:0] SJW_RST      = 5'h03;
  localparam logic [4:0] SEG2_MIN     = 5'h02;

  // Timing figures
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_NOM_NS    = 8000;
  localparam int BIT_MIN_NS    = 7904;
  localparam int BIT_MAX_NS    = 8096;
  localparam int TQ_MAX_NS     = 1000;
  localparam int TQ_MIN_NS     = 615;
  localparam int BIT_NOM_CLK   = BIT_NOM_NS / CLK_PERIOD_NS;
  localparam int BIT_MIN_CLK   = (BIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT_MAX_CLK   = BIT_MAX_NS / CLK_PERIOD_NS;
  localparam int TQ_MAX_CLK    = TQ_MAX_NS / CLK_PERIOD_NS;
  localparam logic [7:0] PRESCALE_MAX = 8'(TQ_MAX_CLK - 1);

  // Bit segments
  typedef enum logic [1:0] {SEG_SYNC, SEG_PHASE1, SEG_PHASE2} seg_t;

  // Programmed timing carried as one bundle
  typedef struct packed {
    logic [7:0] prescale;
    logic [4:0] seg1;
    logic [4:0] seg2;
    logic [4:0] sjw;
  } timing_cfg_t;

endpackage

// ### rtl/can_bit_timing.sv
// CAN bit timing unit with APB register access
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps

module can_bit_timing (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // CAN receive line and bit events
  input  wire logic        rx_line,
  input  wire logic        bus_idle,
  output logic             sample_bit,
  output logic             sample_strobe,
  output logic             bit_start
);

  can_bit_timing_pkg::timing_cfg_t cfg_reg;
  logic                            enable_reg;
  logic                            rx_prev_reg;
  logic [7:0]                      tq_cnt_reg;
  logic [4:0]                      seg_cnt_reg;
  logic [5:0]                      seg_len_reg;
  can_bit_timing_pkg::seg_t        seg_reg;
  logic [15:0]                     resync_cnt_reg;
  logic                            hard_sync_seen_reg;

  logic apb_wr;
  logic apb_rd;
  logic tq_tick;
  logic edge_fall;
  logic seg_done;
  logic [4:0] p1_len;
  logic [5:0] p1_ext;
  logic [5:0] p2_cut;
  logic       p2_restart;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
    return (a < b) ? a : b;
  endfunction

  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Register writes; divider clamped so a quantum never exceeds its ceiling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg.prescale <= can_bit_timing_pkg::PRESCALE_RST;
      cfg_reg.seg1     <= can_bit_timing_pkg::SEG1_RST;
      cfg_reg.seg2     <= can_bit_timing_pkg::SEG2_RST;
      cfg_reg.sjw      <= can_bit_timing_pkg::SJW_RST;
      enable_reg       <= 1'b1;
    end else if (apb_wr) begin
      if (addr_hit(paddr, can_bit_timing_pkg::OFS_PRESCALE)) begin
        cfg_reg.prescale <= (pwdata[7:0] > can_bit_timing_pkg::PRESCALE_MAX) ?
                            can_bit_timing_pkg::PRESCALE_MAX : pwdata[7:0];
      end
      if (addr_hit(paddr, can_bit_timing_pkg::OFS_SEGMENT)) begin
        cfg_reg.seg1 <= pwdata[can_bit_timing_pkg::SEG1_LSB +: can_bit_timing_pkg::FIELD_W];
        cfg_reg.seg2 <= (pwdata[can_bit_timing_pkg::SEG2_LSB +: can_bit_timing_pkg::FIELD_W] <
                         can_bit_timing_pkg::SEG2_MIN) ? can_bit_timing_pkg::SEG2_MIN :
                        pwdata[can_bit_timing_pkg::SEG2_LSB +: can_bit_timing_pkg::FIELD_W];
        cfg_reg.sjw  <= pwdata[can_bit_timing_pkg::SJW_LSB +: can_bit_timing_pkg::FIELD_W];
      end
      if (addr_hit(paddr, can_bit_timing_pkg::OFS_CONTROL)) begin
        enable_reg <= pwdata[0];
      end
    end
  end

  // Read data from flip-flops; unmapped addresses read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd && !penable) begin
      prdata <= 32'h0000_0000;
      if (addr_hit(paddr, can_bit_timing_pkg::OFS_PRESCALE)) begin
        prdata[7:0] <= cfg_reg.prescale;
      end
      if (addr_hit(paddr, can_bit_timing_pkg::OFS_SEGMENT)) begin
        prdata[can_bit_timing_pkg::SEG1_LSB +: can_bit_timing_pkg::FIELD_W] <= cfg_reg.seg1;
        prdata[can_bit_timing_pkg::SEG2_LSB +: can_bit_timing_pkg::FIELD_W] <= cfg_reg.seg2;
        prdata[can_bit_timing_pkg::SJW_LSB +: can_bit_timing_pkg::FIELD_W]  <= cfg_reg.sjw;
      end
      if (addr_hit(paddr, can_bit_timing_pkg::OFS_CONTROL)) begin
        prdata[0] <= enable_reg;
      end
      if (addr_hit(paddr, can_bit_timing_pkg::OFS_STATUS)) begin
        prdata[1:0]  <= seg_reg;
        prdata[2]    <= hard_sync_seen_reg;
        prdata[31:16] <= resync_cnt_reg;
      end
    end
  end

  // Quantum divider: prescale+1 clocks per quantum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tq_cnt_reg <= 8'h00;
    end else if (!enable_reg || (edge_fall && bus_idle) || tq_tick || p2_restart) begin
      // A cut that ends the bit restarts the divider so the next sync is a full quantum
      tq_cnt_reg <= 8'h00;
    end else begin
      tq_cnt_reg <= tq_cnt_reg + 8'h01;
    end
  end

  // Compare with >= so a smaller divider written mid-quantum does not wrap the counter
  assign tq_tick   = enable_reg && (tq_cnt_reg >= cfg_reg.prescale);
  assign p2_restart = edge_fall && !bus_idle && seg_reg == can_bit_timing_pkg::SEG_PHASE2 &&
                      (6'({1'b0, cfg_reg.seg2}) - 6'({1'b0, seg_cnt_reg}) <= p2_cut);
  assign edge_fall = rx_prev_reg && !rx_line;
  assign p1_len    = cfg_reg.seg1;
  assign p1_ext    = 6'({1'b0, p1_len}) + 6'({1'b0, cfg_reg.sjw});
  assign p2_cut    = min6(6'({1'b0, cfg_reg.sjw}), 6'({1'b0, cfg_reg.seg2}));
  assign seg_done  = tq_tick && (6'({1'b0, seg_cnt_reg}) + 6'h01 >= seg_len_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_line;
    end
  end

  // Segment sequencer: sync, first phase, second phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_reg     <= can_bit_timing_pkg::SEG_SYNC;
      seg_cnt_reg <= 5'h00;
      seg_len_reg <= 6'h01;
    end else if (!enable_reg || (edge_fall && bus_idle)) begin
      seg_reg     <= can_bit_timing_pkg::SEG_SYNC;
      seg_cnt_reg <= 5'h00;
      seg_len_reg <= 6'h01;
    end else if (edge_fall && seg_reg == can_bit_timing_pkg::SEG_PHASE1) begin
      // Lengthen by the quanta already elapsed, capped at the jump width
      seg_len_reg <= 6'({1'b0, p1_len}) +
                     min6(6'({1'b0, seg_cnt_reg}) + 6'h01, 6'({1'b0, cfg_reg.sjw}));
      if (tq_tick) begin
        seg_cnt_reg <= seg_cnt_reg + 5'h01;
      end
    end else if (edge_fall && seg_reg == can_bit_timing_pkg::SEG_PHASE2) begin
      // Cut the segment short; end this bit now if the cut covers the remainder
      if (6'({1'b0, cfg_reg.seg2}) - 6'({1'b0, seg_cnt_reg}) <= p2_cut) begin
        seg_reg     <= can_bit_timing_pkg::SEG_SYNC;
        seg_cnt_reg <= 5'h00;
        seg_len_reg <= 6'h01;
      end else begin
        seg_len_reg <= 6'({1'b0, cfg_reg.seg2}) - p2_cut;
      end
    end else if (seg_done) begin
      seg_cnt_reg <= 5'h00;
      unique case (seg_reg)
        can_bit_timing_pkg::SEG_SYNC: begin
          seg_reg     <= can_bit_timing_pkg::SEG_PHASE1;
          seg_len_reg <= 6'({1'b0, p1_len});
        end
        can_bit_timing_pkg::SEG_PHASE1: begin
          seg_reg     <= can_bit_timing_pkg::SEG_PHASE2;
          seg_len_reg <= 6'({1'b0, cfg_reg.seg2});
        end
        can_bit_timing_pkg::SEG_PHASE2: begin
          seg_reg     <= can_bit_timing_pkg::SEG_SYNC;
          seg_len_reg <= 6'h01;
        end
        default: begin
          seg_reg     <= can_bit_timing_pkg::SEG_SYNC;
          seg_len_reg <= 6'h01;
        end
      endcase
    end else if (tq_tick) begin
      seg_cnt_reg <= seg_cnt_reg + 5'h01;
    end
  end

  // Single sample at the first/second phase boundary; no majority vote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_bit    <= 1'b1;
      sample_strobe <= 1'b0;
      bit_start     <= 1'b0;
    end else begin
      sample_strobe <= seg_done && seg_reg == can_bit_timing_pkg::SEG_PHASE1;
      bit_start     <= seg_done && seg_reg == can_bit_timing_pkg::SEG_SYNC;
      if (seg_done && seg_reg == can_bit_timing_pkg::SEG_PHASE1) begin
        sample_bit <= rx_line;
      end
    end
  end

  // Status: count of resynchronisations, hard sync seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resync_cnt_reg     <= 16'h0000;
      hard_sync_seen_reg <= 1'b0;
    end else begin
      if (edge_fall && !bus_idle && seg_reg != can_bit_timing_pkg::SEG_SYNC) begin
        resync_cnt_reg <= resync_cnt_reg + 16'h0001;
      end
      if (edge_fall && bus_idle) begin
        hard_sync_seen_reg <= 1'b1;
      end
    end
  end

  // Assertions
  logic [15:0] bit_clk_cnt;
  logic [15:0] bit_clks;
  logic        clean_bit_reg;
  assign bit_clks = (16'({8'h00, cfg_reg.prescale}) + 16'h0001) *
                    (16'h0001 + 16'(cfg_reg.seg1) + 16'(cfg_reg.seg2));

  // A bit counts as clean when no edge, write or disable touched it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clean_bit_reg <= 1'b0;
    end else if (edge_fall || apb_wr || !enable_reg) begin
      clean_bit_reg <= 1'b0;
    end else if (bit_start) begin
      clean_bit_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_clk_cnt <= 16'h0000;
    end else if (bit_start) begin
      bit_clk_cnt <= 16'h0001;
    end else begin
      bit_clk_cnt <= bit_clk_cnt + 16'h0001;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  tq_ceiling_a: assert property (cfg_reg.prescale <= can_bit_timing_pkg::PRESCALE_MAX)
    else $error("quantum divider above ceiling");
  sync_one_tq_a: assert property (seg_reg == can_bit_timing_pkg::SEG_SYNC |->
      seg_len_reg == 6'h01)
    else $error("sync segment not one quantum");
  sample_single_a: assert property (sample_strobe |-> ##1 !sample_strobe)
    else $error("more than one sample strobe");
  sample_value_a: assert property (sample_strobe |-> sample_bit == $past(rx_line))
    else $error("sample does not match line");
  hard_sync_a: assert property (edge_fall && bus_idle |=> seg_reg == can_bit_timing_pkg::SEG_SYNC
      && tq_cnt_reg == 8'h00)
    else $error("hard sync did not restart bit");
  phase1_ext_a: assert property (seg_reg == can_bit_timing_pkg::SEG_PHASE1 |->
      seg_len_reg <= p1_ext)
    else $error("first phase extended beyond jump width");
  phase2_cut_a: assert property (seg_reg == can_bit_timing_pkg::SEG_PHASE2 |->
      seg_len_reg + p2_cut >= 6'({1'b0, cfg_reg.seg2}))
    else $error("second phase cut beyond jump width");
  nominal_bit_a: assert property (bit_start && clean_bit_reg |->
      bit_clk_cnt == bit_clks)
    else $error("undisturbed bit length wrong");

  start_c: cover property (bit_start);
  sample_c: cover property (sample_strobe ##[1:400] sample_strobe);
  hard_c: cover property (edge_fall && bus_idle);
  resync_c: cover property (edge_fall && seg_reg == can_bit_timing_pkg::SEG_PHASE2);

endmodule

// ### tb/can_peer_model.sv
// Model of the other nodes sharing the bus
`timescale 1ns/10ps
module can_peer_model (
  // Clock
  input  wire logic pclk,
  // Bus seen by the receiver
  output logic      rx_line,
  output logic      bus_idle
);
  // The bus is pulled recessive when no node drives it
  initial begin
    rx_line  = 1'b1;
    bus_idle = 1'b0;
  end

  // Dominant stretch of len clocks, then release to recessive
  task automatic pulse(input int len, input logic idle);
    @(posedge pclk);
    bus_idle <= idle;
    rx_line  <= 1'b0;
    repeat (len) @(posedge pclk);
    rx_line  <= 1'b1;
    bus_idle <= 1'b0;
  endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the CAN bit timing block
`timescale 1ns/10ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, lfsr;
  logic [31:0] pwdata, prdata;
  logic        rx_line, bus_idle, sample_bit, sample_strobe, bit_start;
  logic [31:0] exp_q[$];
  int          bad_count, n_tests, cyc, t0, t1, t2;

  can_bit_timing can_bit_timing_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_line(rx_line), .bus_idle(bus_idle),
    .sample_bit(sample_bit), .sample_strobe(sample_strobe), .bit_start(bit_start));
  can_peer_model can_peer_model_i (.pclk(pclk), .rx_line(rx_line), .bus_idle(bus_idle));

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic test_done();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Cycle spans are bench counts, so a window is enough
  task automatic cmp_span(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("Error at %0t: span %h outside %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      bad_count++;
      test_done();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Read data is judged at the edge that completes the access
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      cmp32({31'h0, pslverr}, 32'h0);
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("Error at %0t: read with no expectation, got %h", $time, prdata);
      end
      else cmp32(prdata, exp_q.pop_front());
    end
  end

  task automatic wait_ev(input bit smp, output int t);
    int k;
    for (k = 0; k < 2000; k++) begin
      @(posedge pclk);
      if ((smp ? sample_strobe : bit_start) === 1'b1) break;
    end
    if (k == 2000) begin
      bad_count++;
      test_done();
    end
    t = cyc;
  endtask

  task automatic frame(input int s1);
    wait_ev(0, t0);
    wait_ev(1, t1);
    wait_ev(0, t2);
    cmp_span(t2 - t0, can_bit_timing_pkg::BIT_NOM_CLK, can_bit_timing_pkg::BIT_NOM_CLK);
    cmp_span(t1 - t0, s1, s1);
  endtask

  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    lfsr = 8'd178;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 32'h00000027);
    rd(8'h04, 32'h00030304);
    rd(8'h08, 32'h00000001);
    rd(8'h10, 32'h00000000);
    frame(160);
    $display("test reset timing done");
    // Divider beyond the quantum cap must clamp
    apb(1'b1, 8'h00, 32'h000000FF);
    rd(8'h00, 32'h00000027);
    apb(1'b1, 8'h00, 32'h0000001F);
    apb(1'b1, 8'h04, 32'h00040405);
    wait_ev(0, t0);
    frame(160);
    $display("test ten quanta done");
    apb(1'b1, 8'h00, 32'h00000027);
    apb(1'b1, 8'h04, 32'h00030304);
    wait_ev(0, t0);
    wait_ev(0, t0);
    repeat (78) @(posedge pclk);
    fork can_peer_model_i.pulse(40, 1'b0); join_none
    wait_ev(0, t2);
    cmp_span(t2 - t0, 321, 440);
    wait_ev(0, t0);
    wait_ev(1, t1);
    repeat (20) @(posedge pclk);
    fork can_peer_model_i.pulse(40, 1'b0); join_none
    wait_ev(0, t2);
    cmp_span(t2 - t0, 200, 319);
    $display("test resync done");
    lfsr = nxt(lfsr);
    repeat (10 + lfsr[6:0]) @(posedge pclk);
    t0 = cyc;
    fork can_peer_model_i.pulse(320, 1'b1); join_none
    wait_ev(0, t2);
    cmp_span(t2 - t0, 39, 45);
    wait_ev(1, t1);
    cmp_span(t1 - t2, 160, 160);
    cmp32({31'h0, sample_bit}, 32'h0);
    wait_ev(1, t1);
    cmp32({31'h0, sample_bit}, 32'h1);
    $display("test hard sync done");
    test_done();
  end
endmodule
